// >>> design/rtf_pkg.sv
package rtf_pkg;
  // register byte addresses
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_TX_OFFS  = 8'h04;
  localparam logic [7:0]  ADR_TX_DELAY = 8'h08;
  localparam logic [7:0]  ADR_TX_INTV  = 8'h0C;
  localparam logic [7:0]  ADR_STATUS   = 8'h10;
  localparam logic [7:0]  ADR_TX_CNT   = 8'h14;
  localparam logic [7:0]  ADR_RX_CNT   = 8'h18;
  localparam logic [2:0]  ADR_PAY_BASE = 3'h1;   // adr[7:5], payload words at 0x20..0x3C
  // control fields and reset values
  localparam int          CTRL_TX_EN   = 0;
  localparam int          CTRL_RX_EN   = 1;
  localparam int          CTRL_PAY_REG = 2;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;
  localparam logic [31:0] TX_INTV_RESET = 32'h000F4240;
  // time and frame layout
  localparam logic [31:0] NS_PER_SEC   = 32'h3B9ACA00;
  localparam logic [7:0]  MSG_ID       = 8'h01;
  localparam logic [7:0]  APP_VERSION  = 8'h01;
  localparam logic [15:0] PAYLOAD_BYTES = 16'h0020;
  localparam logic [4:0]  W_HEAD       = 5'h00;
  localparam logic [4:0]  W_CNT        = 5'h01;
  localparam logic [4:0]  W_SEC        = 5'h02;
  localparam logic [4:0]  W_NSEC       = 5'h03;
  localparam logic [4:0]  W_INFO       = 5'h04;
  localparam logic [4:0]  W_STR        = 5'h05;
  localparam logic [4:0]  W_PAY        = 5'h10;
  localparam logic [4:0]  W_CRC        = 5'h18;
  localparam logic [31:0] CRC_POLY     = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
  localparam logic [7:0]  KEY_TX       = 8'h54;
  localparam logic [7:0]  KEY_RX       = 8'h52;

  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_ALIGN = 3'b001,
    T_WAIT  = 3'b010,
    T_SEND  = 3'b011,
    T_STAMP = 3'b100
  } rtf_tx_state_t;

  typedef enum logic [1:0] {
    R_IDLE  = 2'b00,
    R_RECV  = 2'b01,
    R_STAMP = 2'b10
  } rtf_rx_state_t;
endpackage : rtf_pkg

// >>> design/rtf_talker_listener.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - send time from offset, delay, interval
// - align to whole second, then periodic
// - refresh metadata, payload from app or registers
// - payload always thirty-two bytes
// - after frame sent, request tx timestamp
// - tx stamp timeout restarts, flags invalid
// - generator wraps frame, CRC, streams out
// - scheduler starts generator, generator reports done
// - 32-bit key with every stamp request
// - parser takes frames, extracts payload, metadata
// - parser enabled, reports dropped/valid/wrong version
// - discard pulse, separate version mismatch pulse
// - parser extracts data length field
// - after frame received, request rx timestamp
// - rx stamp timeout flags invalid, resumes
// - stamp found marks record complete
// - app-usable strobe even without stamp
module rtf_talker_listener import rtf_pkg::*; #(
  parameter int unsigned    SYS_CLOCK_PERIOD_NS     = 20,
  parameter int unsigned    TX_STAMP_WAIT_LIMIT_NS  = 500000,
  parameter int unsigned    RX_STAMP_WAIT_LIMIT_NS  = 10000,
  parameter bit             PAYLOAD_FROM_REGISTERS_OPTION = 1'b1,
  parameter logic [255:0]   MAKER_STRING = {32{8'h20}},
  parameter logic [79:0]    UNIT_STRING  = {10{8'h20}}
) (
  // system
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  // wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // synchronized time {seconds, nanoseconds}
  input  wire logic [63:0]  synced_time_value_i,
  input  wire logic         synced_time_valid_i,
  // application source
  input  wire logic [7:0]   app_id_i,
  input  wire logic [255:0] app_data_i,
  input  wire logic [15:0]  app_seq_i,
  input  wire logic         app_data_valid_i,
  // tx timestamper
  output logic              tx_stamp_lookup_request_o,
  output logic      [31:0]  tx_stamp_lookup_key_o,
  input  wire logic         tx_stamp_lookup_done_i,
  input  wire logic         tx_stamp_found_i,
  // rx timestamper
  output logic              rx_stamp_lookup_request_o,
  output logic      [31:0]  rx_stamp_lookup_key_o,
  input  wire logic         rx_stamp_lookup_done_i,
  input  wire logic         rx_stamp_found_i,
  input  wire logic [63:0]  rx_stamp_value_i,
  // outgoing stream
  output logic              axis_tx_tvalid_o,
  input  wire logic         axis_tx_tready_i,
  output logic      [31:0]  axis_tx_tdata_o,
  output logic              axis_tx_tlast_o,
  // incoming stream
  input  wire logic         axis_rx_tvalid_i,
  output logic              axis_rx_tready_o,
  input  wire logic [31:0]  axis_rx_tdata_i,
  input  wire logic         axis_rx_tlast_i,
  // received record
  output logic      [255:0] rx_payload_o,
  output logic      [7:0]   rx_app_id_o,
  output logic      [15:0]  rx_seq_o,
  output logic      [15:0]  rx_len_o,
  output logic      [63:0]  rx_sent_time_o,
  output logic      [63:0]  rx_stamp_o,
  output logic              rx_stamp_valid_o,
  output logic              rx_record_complete_o,
  output logic              rx_record_usable_for_apps_o,
  output logic              rx_discard_pulse_o,
  output logic              rx_version_mismatch_pulse_o
);

  localparam int unsigned TX_WAIT_RAW = TX_STAMP_WAIT_LIMIT_NS / SYS_CLOCK_PERIOD_NS;
  localparam int unsigned RX_WAIT_RAW = RX_STAMP_WAIT_LIMIT_NS / SYS_CLOCK_PERIOD_NS;
  localparam logic [31:0] TX_WAIT_CYC = 32'((TX_WAIT_RAW < 1) ? 1 : TX_WAIT_RAW);
  localparam logic [31:0] RX_WAIT_CYC = 32'((RX_WAIT_RAW < 1) ? 1 : RX_WAIT_RAW);

  typedef struct packed {
    logic               ack;
    logic [31:0]        rdat;
    logic [2:0]         ctrl;
    logic [31:0]        offs;
    logic [31:0]        dly;
    logic [31:0]        intv;
    logic [7:0][31:0]   preg;
    rtf_tx_state_t      ts;
    logic [63:0]        target;
    logic [31:0]        fcnt;
    logic               stamp_ok;
    logic [7:0]         app_id;
    logic [15:0]        app_seq;
    logic [255:0]       app_data;
    logic [63:0]        snap;
    logic [7:0]         fl;
    logic [255:0]       pay;
    logic [7:0]         fid;
    logic [15:0]        fseq;
    logic               busy;
    logic               done;
    logic [4:0]         gidx;
    logic [31:0]        crc;
    logic               axv;
    logic [31:0]        axd;
    logic               axl;
    logic               treq;
    logic [31:0]        tkey;
    logic [31:0]        twait;
    rtf_rx_state_t      rs;
    logic               rrdy;
    logic [4:0]         ridx;
    logic [31:0]        rcrc;
    logic               rbad;
    logic               rmsg;
    logic               rver;
    logic [7:0]         rid;
    logic [15:0]        rseq;
    logic [15:0]        rlen;
    logic [255:0]       rpay;
    logic [63:0]        rsent;
    logic               rreq;
    logic [31:0]        rkey;
    logic [31:0]        rwait;
    logic [63:0]        rstamp;
    logic               rsok;
    logic               rcomp;
    logic               rusable;
    logic               rdisc;
    logic               rmis;
    logic [31:0]        rcnt;
  } rtf_state_t;

  rtf_state_t r;
  rtf_state_t next_r;
  logic       regsrc;

  assign regsrc = PAYLOAD_FROM_REGISTERS_OPTION && r.ctrl[CTRL_PAY_REG];

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] x;
    x = c;
    for (int i = 31; i >= 0; i--) begin
      x = (x[31] ^ d[i]) ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction : crc_step

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) m[8*b +: 8] = d[8*b +: 8];
    end
    return m;
  endfunction : wmerge

  // frame word i; strings go out first character first
  function automatic logic [31:0] tx_word(input rtf_state_t s, input logic [4:0] i);
    logic [351:0] str;
    int           k;
    str = {MAKER_STRING, UNIT_STRING, 16'h2020};
    k   = 0;
    if (i == W_HEAD)      tx_word = {MSG_ID, s.fid, s.fseq};
    else if (i == W_CNT)  tx_word = s.fcnt;
    else if (i == W_SEC)  tx_word = s.snap[63:32];
    else if (i == W_NSEC) tx_word = s.snap[31:0];
    else if (i == W_INFO) tx_word = {s.fl, APP_VERSION, PAYLOAD_BYTES};
    else if (i < W_PAY) begin
      k       = int'(i) - int'(W_STR);
      tx_word = str[351 - 32*k -: 32];
    end else begin
      k       = int'(i) - int'(W_PAY);
      tx_word = s.pay[32*k +: 32];
    end
  endfunction : tx_word

  always_comb begin
    logic [31:0] tns;
    logic [31:0] c;
    logic [31:0] w;
    logic        bad;
    int          k;
    next_r = r;
    tns    = '0;
    c      = '0;
    w      = axis_rx_tdata_i;
    bad    = 1'b0;
    k      = 0;
    next_r.done    = 1'b0;
    next_r.rcomp   = 1'b0;
    next_r.rusable = 1'b0;
    next_r.rdisc   = 1'b0;
    next_r.rmis    = 1'b0;

    // wishbone: ack one cycle after request, write lands on the acked edge
    next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      next_r.rdat = 32'h00000000;
      case (wb_adr_i)
        ADR_CTRL:     next_r.rdat = {29'h0, r.ctrl};
        ADR_TX_OFFS:  next_r.rdat = r.offs;
        ADR_TX_DELAY: next_r.rdat = r.dly;
        ADR_TX_INTV:  next_r.rdat = r.intv;
        ADR_STATUS:   next_r.rdat = {24'h0, r.rs, r.ts, 1'b0, r.stamp_ok, r.rsok};
        ADR_TX_CNT:   next_r.rdat = r.fcnt;
        ADR_RX_CNT:   next_r.rdat = r.rcnt;
        default: begin
          if (wb_adr_i[7:5] == ADR_PAY_BASE) next_r.rdat = r.preg[wb_adr_i[4:2]];
        end
      endcase
    end
    if (wb_cyc_i && wb_stb_i && r.ack && wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL:     next_r.ctrl = 3'(wmerge({29'h0, r.ctrl}, wb_dat_i, wb_sel_i));
        ADR_TX_OFFS:  next_r.offs = wmerge(r.offs, wb_dat_i, wb_sel_i);
        ADR_TX_DELAY: next_r.dly  = wmerge(r.dly, wb_dat_i, wb_sel_i);
        ADR_TX_INTV:  next_r.intv = wmerge(r.intv, wb_dat_i, wb_sel_i);
        default: begin
          if (wb_adr_i[7:5] == ADR_PAY_BASE)
            next_r.preg[wb_adr_i[4:2]] = wmerge(r.preg[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
        end
      endcase
    end

    if (app_data_valid_i) begin
      next_r.app_id   = app_id_i;
      next_r.app_seq  = app_seq_i;
      next_r.app_data = app_data_i;
    end

    // talker scheduling
    case (r.ts)
      T_IDLE: if (r.ctrl[CTRL_TX_EN]) next_r.ts = T_ALIGN;
      T_ALIGN: begin
        if (!r.ctrl[CTRL_TX_EN]) next_r.ts = T_IDLE;
        else if (synced_time_valid_i) begin
          next_r.target = {synced_time_value_i[63:32] + 32'h1, r.offs + r.dly};
          next_r.ts     = T_WAIT;
        end
      end
      T_WAIT: begin
        if (!r.ctrl[CTRL_TX_EN]) next_r.ts = T_IDLE;
        else if (synced_time_valid_i && synced_time_value_i >= r.target) begin
          tns = r.target[31:0] + r.intv;
          if (tns >= NS_PER_SEC) begin
            next_r.target = {r.target[63:32] + 32'h1, tns - NS_PER_SEC};
          end else begin
            next_r.target = {r.target[63:32], tns};
          end
          next_r.fcnt = r.fcnt + 32'h1;
          next_r.snap = synced_time_value_i;
          next_r.fid  = r.app_id;
          next_r.fseq = r.app_seq;
          next_r.pay  = regsrc ? r.preg : r.app_data;
          next_r.fl   = {6'h0, regsrc, r.stamp_ok};
          next_r.busy = 1'b1;
          next_r.gidx = W_HEAD;
          next_r.crc  = CRC_INIT;
          next_r.axv  = 1'b1;
          next_r.axl  = 1'b0;
          next_r.axd  = tx_word(next_r, W_HEAD);
          next_r.ts   = T_SEND;
        end
      end
      T_SEND: begin
        if (r.done) begin
          next_r.treq  = 1'b1;
          next_r.tkey  = {KEY_TX, r.fcnt[23:0]};
          next_r.twait = 32'h0;
          next_r.ts    = T_STAMP;
        end
      end
      T_STAMP: begin
        if (tx_stamp_lookup_done_i) begin
          next_r.treq     = 1'b0;
          next_r.stamp_ok = tx_stamp_found_i;
          next_r.ts       = T_WAIT;
        end else if (r.twait >= TX_WAIT_CYC - 32'h1) begin
          next_r.treq     = 1'b0;
          next_r.stamp_ok = 1'b0;
          next_r.ts       = T_WAIT;
        end else begin
          next_r.twait = r.twait + 32'h1;
        end
      end
      default: next_r.ts = T_IDLE;
    endcase

    // frame generator: registered stream stage, crc over words before the last
    if (r.axv && axis_tx_tready_i) begin
      if (r.gidx == W_CRC) begin
        next_r.axv  = 1'b0;
        next_r.axl  = 1'b0;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        c           = crc_step(r.crc, r.axd);
        next_r.crc  = c;
        next_r.gidx = r.gidx + 5'h1;
        next_r.axl  = (r.gidx + 5'h1 == W_CRC);
        next_r.axd  = (r.gidx + 5'h1 == W_CRC) ? ~c : tx_word(r, r.gidx + 5'h1);
      end
    end

    // listener
    case (r.rs)
      R_IDLE: begin
        if (r.ctrl[CTRL_RX_EN]) begin
          next_r.rs   = R_RECV;
          next_r.ridx = W_HEAD;
          next_r.rcrc = CRC_INIT;
          next_r.rbad = 1'b0;
        end
      end
      R_RECV: begin
        if (r.rrdy && axis_rx_tvalid_i) begin
          if (r.ridx < W_CRC) next_r.rcrc = crc_step(r.rcrc, w);
          if (r.ridx == W_HEAD) begin
            next_r.rmsg = (w[31:24] == MSG_ID);
            next_r.rid  = w[23:16];
            next_r.rseq = w[15:0];
          end
          if (r.ridx == W_SEC)  next_r.rsent[63:32] = w;
          if (r.ridx == W_NSEC) next_r.rsent[31:0] = w;
          if (r.ridx == W_INFO) begin
            next_r.rver = (w[23:16] == APP_VERSION);
            next_r.rlen = w[15:0];
          end
          if (r.ridx >= W_PAY && r.ridx < W_CRC) begin
            k = int'(r.ridx) - int'(W_PAY);
            next_r.rpay[32*k +: 32] = w;
          end
          if (r.ridx == W_CRC && w != ~r.rcrc) next_r.rbad = 1'b1;
          if (r.ridx > W_CRC) next_r.rbad = 1'b1;
          if (r.ridx != 5'h1F) next_r.ridx = r.ridx + 5'h1;
          if (axis_rx_tlast_i) begin
            bad         = next_r.rbad || (r.ridx != W_CRC) || !next_r.rmsg;
            next_r.ridx = W_HEAD;
            next_r.rcrc = CRC_INIT;
            next_r.rbad = 1'b0;
            if (bad) next_r.rdisc = 1'b1;
            else if (!next_r.rver) next_r.rmis = 1'b1;
            else begin
              next_r.rreq  = 1'b1;
              next_r.rkey  = {KEY_RX, next_r.rid, next_r.rseq};
              next_r.rwait = 32'h0;
              next_r.rs    = R_STAMP;
            end
          end
        end else if (!r.ctrl[CTRL_RX_EN] && r.ridx == W_HEAD) begin
          next_r.rs = R_IDLE;
        end
      end
      R_STAMP: begin
        if (rx_stamp_lookup_done_i) begin
          next_r.rreq    = 1'b0;
          next_r.rsok    = rx_stamp_found_i;
          next_r.rstamp  = rx_stamp_value_i;
          next_r.rcomp   = rx_stamp_found_i;
          next_r.rusable = 1'b1;
          next_r.rcnt    = r.rcnt + 32'h1;
          next_r.rs      = R_RECV;
        end else if (r.rwait >= RX_WAIT_CYC - 32'h1) begin
          next_r.rreq    = 1'b0;
          next_r.rsok    = 1'b0;
          next_r.rusable = 1'b1;
          next_r.rcnt    = r.rcnt + 32'h1;
          next_r.rs      = R_RECV;
        end else begin
          next_r.rwait = r.rwait + 32'h1;
        end
      end
      default: next_r.rs = R_IDLE;
    endcase
    next_r.rrdy = (next_r.rs == R_RECV);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      r      <= '0;
      r.ctrl <= CTRL_RESET;
      r.intv <= TX_INTV_RESET;
      r.crc  <= CRC_INIT;
      r.rcrc <= CRC_INIT;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o                    = r.rdat;
  assign wb_ack_o                    = r.ack;
  assign tx_stamp_lookup_request_o   = r.treq;
  assign tx_stamp_lookup_key_o       = r.tkey;
  assign rx_stamp_lookup_request_o   = r.rreq;
  assign rx_stamp_lookup_key_o       = r.rkey;
  assign axis_tx_tvalid_o            = r.axv;
  assign axis_tx_tdata_o             = r.axd;
  assign axis_tx_tlast_o             = r.axl;
  assign axis_rx_tready_o            = r.rrdy;
  assign rx_payload_o                = r.rpay;
  assign rx_app_id_o                 = r.rid;
  assign rx_seq_o                    = r.rseq;
  assign rx_len_o                    = r.rlen;
  assign rx_sent_time_o              = r.rsent;
  assign rx_stamp_o                  = r.rstamp;
  assign rx_stamp_valid_o            = r.rsok;
  assign rx_record_complete_o        = r.rcomp;
  assign rx_record_usable_for_apps_o = r.rusable;
  assign rx_discard_pulse_o          = r.rdisc;
  assign rx_version_mismatch_pulse_o = r.rmis;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  property p_send_due;
    $rose(r.busy) |-> $past(synced_time_value_i) >= $past(r.target);
  endproperty
  a_send_due: assert property (p_send_due) else $error("frame started early");

  property p_align;
    (r.ts == T_ALIGN && r.ctrl[CTRL_TX_EN] && synced_time_valid_i) |=>
      r.target == {$past(synced_time_value_i[63:32]) + 32'h1, $past(r.offs + r.dly)};
  endproperty
  a_align: assert property (p_align) else $error("first target not on second");

  property p_payload_src;
    $rose(r.busy) |-> r.pay == ($past(regsrc) ? $past(r.preg) : $past(r.app_data));
  endproperty
  a_payload_src: assert property (p_payload_src) else $error("wrong payload source");

  property p_frame_len;
    (r.axv && r.axl) |-> r.gidx == W_CRC;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

  property p_req_after_send;
    r.done |=> r.treq && r.tkey == {KEY_TX, r.fcnt[23:0]};
  endproperty
  a_req_after_send: assert property (p_req_after_send) else $error("no tx stamp request");

  property p_tx_timeout;
    ($fell(r.treq) && !$past(tx_stamp_lookup_done_i)) |-> !r.stamp_ok && r.ts == T_WAIT;
  endproperty
  a_tx_timeout: assert property (p_tx_timeout) else $error("tx timeout not flagged");

  property p_rx_closed;
    (r.rs != R_RECV) |-> !r.rrdy;
  endproperty
  a_rx_closed: assert property (p_rx_closed) else $error("ready outside receive");

  property p_rx_pulses;
    r.rdisc |-> !r.rmis ##1 !r.rdisc;
  endproperty
  a_rx_pulses: assert property (p_rx_pulses) else $error("discard pulse malformed");

  property p_rx_timeout;
    ($fell(r.rreq) && !$past(rx_stamp_lookup_done_i)) |-> r.rusable && !r.rcomp && !r.rsok;
  endproperty
  a_rx_timeout: assert property (p_rx_timeout) else $error("rx timeout not flagged");

  property p_rx_complete;
    r.rcomp |-> r.rusable && r.rsok;
  endproperty
  a_rx_complete: assert property (p_rx_complete) else $error("complete without stamp");

endmodule : rtf_talker_listener
`default_nettype wire

// >>> tb/rtf_stamp_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtf_stamp_model (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // lookup handshake
  input  wire logic        req_i,
  input  wire logic        answer_i,
  output logic             done_o,
  output logic             found_o,
  output logic      [63:0] value_o
);
  logic [3:0] dly;
  // found and value flip outside a response so stale data never looks valid
  always_ff @(posedge clk_i) begin
    done_o  <= 1'b0;
    found_o <= ~found_o;
    value_o <= ~value_o;
    if (rst_i) begin
      dly     <= 4'h0;
      found_o <= 1'b0;
      value_o <= 64'h0;
    end else if (!req_i) begin
      dly <= 4'h0;
    end else if (answer_i && !done_o) begin
      dly <= dly + 4'h1;
      if (dly == 4'h3) begin
        done_o  <= 1'b1;
        found_o <= 1'b1;
        value_o <= 64'h0000000700001234;
      end
    end
  end
endmodule : rtf_stamp_model
`default_nettype wire

// >>> tb/test_rtf_talker_listener.sv
`timescale 1ns/1ps
`default_nettype none
module test_rtf_talker_listener import rtf_pkg::*;;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, app_id_i = 8'h3C, rx_app_id_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic [15:0] app_seq_i = 16'h0102, rx_seq_o, rx_len_o;
  logic [31:0] wb_dat_i = 32'h0, sec = 32'h5, ns = NS_PER_SEC - 32'h7D0, axis_rx_tdata_i = 32'h0;
  logic [31:0] wb_dat_o, tx_stamp_lookup_key_o, rx_stamp_lookup_key_o, axis_tx_tdata_o, rkey, q, t1;
  logic [255:0] app_data_i = {8{32'h13579BDF}}, rx_payload_o;
  logic app_data_valid_i = 1'b0, axis_tx_tready_i = 1'b0, axis_rx_tvalid_i = 1'b0;
  logic axis_rx_tlast_i = 1'b0, tx_ans = 1'b1, rx_ans = 1'b1, got = 1'b0, synced_time_valid_i = 1'b1;
  logic wb_ack_o, tx_stamp_lookup_request_o, rx_stamp_lookup_request_o, axis_tx_tvalid_o;
  logic axis_tx_tlast_o, axis_rx_tready_o, rx_stamp_valid_o, rx_record_complete_o;
  logic rx_record_usable_for_apps_o, rx_discard_pulse_o, rx_version_mismatch_pulse_o;
  logic tx_stamp_lookup_done_i, tx_stamp_found_i, rx_stamp_lookup_done_i, rx_stamp_found_i;
  logic [63:0] rx_sent_time_o, rx_stamp_o, rx_stamp_value_i;
  wire logic [63:0] synced_time_value_i = {sec, ns};
  logic [31:0] fw [25], f [25], g [25];
  // outcome bits: complete, usable, discard, version mismatch
  logic [3:0] ex [6] = '{4'b1100, 4'b0100, 4'b0010, 4'b0001, 4'b0010, 4'b0010};
  int nw = 0, n = 0, n_fail = 0, cmp_count = 0, np [4] = '{0, 0, 0, 0}, c [4];

  rtf_talker_listener #(
    .SYS_CLOCK_PERIOD_NS(20),
    .TX_STAMP_WAIT_LIMIT_NS(200),
    .RX_STAMP_WAIT_LIMIT_NS(100),
    .PAYLOAD_FROM_REGISTERS_OPTION(1'b1),
    .MAKER_STRING({32{8'h20}}),
    .UNIT_STRING({10{8'h20}})
  ) dut (
    .mclk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .synced_time_value_i, .synced_time_valid_i, .app_id_i, .app_data_i,
    .app_seq_i, .app_data_valid_i, .tx_stamp_lookup_request_o, .tx_stamp_lookup_key_o,
    .tx_stamp_lookup_done_i, .tx_stamp_found_i, .rx_stamp_lookup_request_o,
    .rx_stamp_lookup_key_o, .rx_stamp_lookup_done_i, .rx_stamp_found_i, .rx_stamp_value_i,
    .axis_tx_tvalid_o, .axis_tx_tready_i, .axis_tx_tdata_o, .axis_tx_tlast_o, .axis_rx_tvalid_i,
    .axis_rx_tready_o, .axis_rx_tdata_i, .axis_rx_tlast_i, .rx_payload_o, .rx_app_id_o,
    .rx_seq_o, .rx_len_o, .rx_sent_time_o, .rx_stamp_o, .rx_stamp_valid_o,
    .rx_record_complete_o, .rx_record_usable_for_apps_o, .rx_discard_pulse_o,
    .rx_version_mismatch_pulse_o
  );
  rtf_stamp_model tx_ts (.clk_i(mclk_i), .rst_i(sys_rst_i), .req_i(tx_stamp_lookup_request_o),
    .answer_i(tx_ans), .done_o(tx_stamp_lookup_done_i), .found_o(tx_stamp_found_i), .value_o());
  rtf_stamp_model rx_ts (.clk_i(mclk_i), .rst_i(sys_rst_i), .req_i(rx_stamp_lookup_request_o),
    .answer_i(rx_ans), .done_o(rx_stamp_lookup_done_i), .found_o(rx_stamp_found_i),
    .value_o(rx_stamp_value_i));

  initial forever #10 mclk_i = ~mclk_i;

  // ready toggles so the generator must hold words across stalls
  always @(posedge mclk_i) begin
    axis_tx_tready_i <= ~axis_tx_tready_i;
    if (ns >= NS_PER_SEC - 32'h14) begin
      ns  <= ns + 32'h14 - NS_PER_SEC;
      sec <= sec + 32'h1;
    end else begin
      ns <= ns + 32'h14;
    end
    if (axis_tx_tvalid_o && axis_tx_tready_i) begin
      if (nw < 25) fw[nw] <= axis_tx_tdata_o;
      nw  <= nw + 1;
      got <= axis_tx_tlast_o;
    end
    if (rx_stamp_lookup_request_o) rkey <= rx_stamp_lookup_key_o;
    np <= '{np[0] + int'(rx_record_complete_o), np[1] + int'(rx_record_usable_for_apps_o),
            np[2] + int'(rx_discard_pulse_o), np[3] + int'(rx_version_mismatch_pulse_o)};
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    cmp_count++;
    if (e !== s) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic bound(input string nm, input int k);
    if (k >= 600) begin
      chk(nm, 1'b1, 1'b0);
      end_sim();
    end
  endtask : bound

  task automatic wt(ref logic s, input logic v, input string nm);
    n = 0;
    while (s !== v && n < 600) begin
      @(posedge mclk_i);
      n++;
    end
    bound(nm, n);
  endtask : wt

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge mclk_i);
    wt(wb_ack_o, 1'b1, "ack");
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("register", e, q);
  endtask : rdc

  function automatic logic [31:0] crc(input logic [31:0] w [25]);
    logic [31:0] r;
    r = CRC_INIT;
    for (int i = 0; i < 24; i++)
      for (int b = 31; b >= 0; b--)
        r = {r[30:0], 1'b0} ^ ((r[31] ^ w[i][b]) ? CRC_POLY : 32'h0);
    return ~r;
  endfunction : crc

  task automatic frame();
    nw  = 0;
    got = 1'b0;
    wt(got, 1'b1, "frame");
    chk("words", 25, nw);
    chk("crc", crc(fw), fw[24]);
    chk("head", {MSG_ID, app_id_i, app_seq_i}, fw[0]);
    chk("length", {APP_VERSION, PAYLOAD_BYTES}, fw[4][23:0]);
  endtask : frame

  task automatic send(input int k);
    for (int i = 0; i < k; i++) begin
      axis_rx_tvalid_i <= 1'b1;
      axis_rx_tdata_i  <= f[i];
      axis_rx_tlast_i  <= (i == k - 1);
      @(posedge mclk_i);
      wt(axis_rx_tready_o, 1'b1, "rx ready");
    end
    axis_rx_tvalid_i <= 1'b0;
    axis_rx_tlast_i  <= 1'b0;
    axis_rx_tdata_i  <= ~axis_rx_tdata_i;
  endtask : send

  initial begin
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rdc(ADR_CTRL, 32'h0);
    rdc(ADR_TX_INTV, TX_INTV_RESET);
    wb(1'b1, 8'h1C, 32'hFFFFFFFF);
    rdc(8'h1C, 32'h0);
    wb(1'b1, ADR_TX_OFFS, 32'h64);
    wb(1'b1, ADR_TX_DELAY, 32'h64);
    wb(1'b1, ADR_TX_INTV, 32'hFA0);
    wb(1'b1, 8'h20, 32'hCAFE0001);
    rdc(ADR_TX_INTV, 32'hFA0);
    app_data_valid_i <= 1'b1;
    @(posedge mclk_i);
    app_data_valid_i <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h3);
    $display("test registers done");
    frame();
    chk("slot", 1'b1, fw[3] >= 32'hC8 && fw[3] < 32'h12C);
    chk("second", 32'h6, fw[2]);
    chk("payload", app_data_i[31:0], fw[16]);
    t1 = fw[3];
    g  = fw;
    wt(tx_stamp_lookup_request_o, 1'b1, "tx request");
    chk("tx key", {KEY_TX, fw[1][23:0]}, tx_stamp_lookup_key_o);
    wt(tx_stamp_lookup_request_o, 1'b0, "tx release");
    tx_ans <= 1'b0;
    frame();
    chk("period", 32'hFA0, fw[3] - t1);
    chk("flags", 2'b01, fw[4][25:24]);
    wb(1'b1, ADR_CTRL, 32'h7);
    frame();
    chk("flags", 2'b10, fw[4][25:24]);
    chk("reg payload", 32'hCAFE0001, fw[16]);
    wb(1'b1, ADR_CTRL, 32'h2);
    $display("test talker done");
    for (int k = 0; k < 6; k++) begin
      f = g;
      if (k == 2) f[9] = ~f[9];
      if (k == 3) f[4][23:16] = 8'h02;
      if (k == 4) f[0][31:24] = 8'h02;
      if (k == 3 || k == 4) f[24] = crc(f);
      rx_ans <= (k != 1);
      c = np;
      send(k == 5 ? 24 : 25);
      n = 0;
      while (np == c && n < 600) begin
        @(posedge mclk_i);
        n++;
      end
      bound("outcome", n);
      @(posedge mclk_i);
      chk("outcome", ex[k], {np[0] != c[0], np[1] != c[1], np[2] != c[2], np[3] != c[3]});
      if (k < 2) chk("stamp valid", k == 0, rx_stamp_valid_o);
      if (k == 0) begin
        chk("rx payload", app_data_i[31:0], rx_payload_o[31:0]);
        chk("rx length", PAYLOAD_BYTES, rx_len_o);
        chk("rx id", {app_id_i, app_seq_i}, {rx_app_id_o, rx_seq_o});
        chk("rx stamp", 64'h0000000700001234, rx_stamp_o);
        chk("rx key", {KEY_RX, app_id_i, app_seq_i}, rkey);
        chk("rx sent", {32'h6, t1}, rx_sent_time_o);
      end
    end
    rdc(ADR_STATUS, 32'h40);
    rdc(ADR_TX_CNT, 32'h3);
    rdc(ADR_RX_CNT, 32'h2);
    $display("test listener done");
    end_sim();
  end
endmodule : test_rtf_talker_listener
`default_nettype wire
